// *** design/azb_pkg.sv ***
// Shared constants for the arc zone blocking and event logic
package azb_pkg;
    localparam int ZONES          = 4;
    localparam int CHANS          = 4;
    localparam int RECS           = 12;
    localparam int STAT_W         = 18;
    localparam int COND_W         = 2 * ZONES;
    localparam int NFLAG          = COND_W + STAT_W;
    localparam int EVID_W         = 5;
    localparam int PIN_W          = 14;
    localparam int CUR_W          = 16;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int CYCLE_TIME_NS  = 1000;
    localparam int CYCLE_CLKS     = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ZSENS   = 8'h04;
    localparam logic [7:0] REG_ZMODE   = 8'h08;
    localparam logic [7:0] REG_COND    = 8'h0C;
    localparam logic [7:0] REG_STAT    = 8'h10;
    localparam logic [7:0] REG_MASK_ON = 8'h14;
    localparam logic [7:0] REG_MASK_OF = 8'h18;
    localparam logic [7:0] REG_EVCNT   = 8'h1C;
    localparam logic [7:0] REG_RSEL    = 8'h20;
    localparam logic [7:0] REG_RTIME   = 8'h24;
    localparam logic [7:0] REG_RINFO   = 8'h28;
    localparam logic [7:0] REG_RCURAB  = 8'h2C;
    localparam logic [7:0] REG_RCURCR  = 8'h30;
    // Field positions
    localparam int CTRL_CNT_CLR   = 0;
    localparam int ZM_EN          = 0;
    localparam int ZM_PH          = 1;
    localparam int ZM_RES         = 2;
    localparam int ZM_DI_LO       = 3;
    localparam int ST_PH_BLK      = 0;
    localparam int ST_PH_START    = 1;
    localparam int ST_RES_BLK     = 2;
    localparam int ST_RES_START   = 3;
    localparam int ST_LIGHT       = 4;
    localparam int ST_PRES        = 8;
    localparam int ST_DI          = 12;
    localparam int ST_SFAULT      = 13;
    localparam int ST_IOFAULT     = 17;
    // Reset values
    localparam logic [31:0] ZSENS_RST = 32'h0000_0000;
    localparam logic [31:0] ZMODE_RST = 32'h0000_0000;
    localparam logic [NFLAG-1:0] MASK_RST = {NFLAG{1'b1}};
    typedef enum logic [1:0] {
        AZB_DI_OFF,
        AZB_DI_LIGHT,
        AZB_DI_CURRENT,
        AZB_DI_RSVD
    } azb_di_mode_t;
endpackage

// *** design/azb_sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module azb_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit moves only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) q_r <= '0;
        else       q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end

    assign q_o = q_r;
endmodule // azb_sync3
`default_nettype wire

// *** design/azb_arc_event_block.sv ***
// Arc zone trip/block decision, status flags, events and operation records
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module azb_arc_event_block
    import azb_pkg::*;
#(
    parameter int CYC_CLKS = azb_pkg::CYCLE_CLKS
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic                          block_i,
    input  wire logic                          ph_start_i,
    input  wire logic                          res_start_i,
    input  wire logic [azb_pkg::CHANS-1:0]     light_i,
    input  wire logic [azb_pkg::CHANS-1:0]     pres_i,
    input  wire logic                          di_i,
    input  wire logic [azb_pkg::CHANS-1:0]     sens_fault_i,
    input  wire logic                          io_fault_i,
    input  wire logic [31:0]                   time_ms_i,
    input  wire logic [2:0]                    sg_i,
    input  wire logic [azb_pkg::CUR_W-1:0]     cur_a_i,
    input  wire logic [azb_pkg::CUR_W-1:0]     cur_b_i,
    input  wire logic [azb_pkg::CUR_W-1:0]     cur_c_i,
    input  wire logic [azb_pkg::CUR_W-1:0]     cur_res_i,
    output logic      [azb_pkg::ZONES-1:0]     trip_o,
    output logic      [azb_pkg::ZONES-1:0]     blocked_o,
    output logic      [azb_pkg::STAT_W-1:0]    status_o,
    output logic                               ev_valid_o,
    output logic      [azb_pkg::EVID_W-1:0]    ev_id_o,
    output logic                               ev_on_o,
    output logic      [31:0]                   ev_time_o
);
    import azb_pkg::*;

    initial begin
        if (CYC_CLKS < 2 || CYC_CLKS > 65535)
            $error("CYC_CLKS out of range");
    end

    function automatic logic [EVID_W-1:0] first_set(
        input logic [NFLAG-1:0] v);
        logic [EVID_W-1:0] idx;
        idx = '0;
        for (int i = NFLAG - 1; i >= 0; i--) begin
            if (v[i]) idx = EVID_W'(i);
        end
        return idx;
    endfunction

    function automatic logic [3:0] ring_add(input logic [3:0] a,
                                            input logic [3:0] b);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= 5'(RECS)) s = s - 5'(RECS);
        return s[3:0];
    endfunction

    // Registers and state
    logic [31:0]          zsens_r;
    logic [31:0]          zmode_r;
    logic [NFLAG-1:0]     mask_on_r;
    logic [NFLAG-1:0]     mask_of_r;
    logic [3:0]           rsel_r;
    logic [31:0]          evcnt_r;
    logic [15:0]          cyc_cnt_r;
    logic                 tick_r;
    logic                 blk_r;
    logic [ZONES-1:0]     trip_r;
    logic [ZONES-1:0]     blkd_r;
    logic [ZONES-1:0]     pick_prev_r;
    logic [STAT_W-1:0]    stat_r;
    logic [NFLAG-1:0]     rep_r;
    logic [31:0]          ts_r;
    logic                 ev_valid_r;
    logic [EVID_W-1:0]    ev_id_r;
    logic                 ev_on_r;
    logic [31:0]          ev_time_r;
    logic [31:0]          dat_r;
    logic                 ack_r;
    logic [3:0]           wr_ptr_r;
    logic [31:0]          rec_time_r [RECS];
    logic [EVID_W-1:0]    rec_id_r   [RECS];
    logic [63:0]          rec_cur_r  [RECS];
    logic [7:0]           rec_sens_r [RECS];
    logic [2:0]           rec_sg_r   [RECS];
    logic [RECS-1:0]      rec_vld_r;

    logic [PIN_W-1:0]     pins_s;
    logic [CHANS-1:0]     light_s;
    logic [CHANS-1:0]     pres_s;
    logic                 di_s;
    logic [ZONES-1:0]     pickup;
    logic [NFLAG-1:0]     flags;
    logic [NFLAG-1:0]     diff;
    logic [EVID_W-1:0]    ev_idx;
    logic                 wr_acc;
    logic                 cnt_clr;
    logic [ZONES-1:0]     trip_new;
    logic [3:0]           rd_idx;

    azb_sync3 #(
        .W (PIN_W)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({io_fault_i, sens_fault_i, di_i, pres_i, light_i}),
        .q_o   (pins_s)
    );

    assign light_s = pins_s[3:0];
    assign pres_s  = pins_s[7:4];
    assign di_s    = pins_s[8];

    // Processing cycle timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else begin
            tick_r <= (cyc_cnt_r == 16'(CYC_CLKS - 1));
            if (cyc_cnt_r == 16'(CYC_CLKS - 1)) cyc_cnt_r <= '0;
            else                                 cyc_cnt_r <= cyc_cnt_r + 16'h1;
        end
    end

    // Blocking matrix input held for the whole cycle
    always_ff @(posedge clk_i) begin
        if (rst_i)       blk_r <= 1'b0;
        else if (tick_r) blk_r <= block_i;
    end

    // Zone pick-up from sensors, DI mode and current qualifiers
    always_comb begin
        for (int z = 0; z < ZONES; z++) begin
            logic [7:0]   zs;
            logic [7:0]   zm;
            logic         hit;
            logic         qual;
            azb_di_mode_t dm;
            zs   = zsens_r[8*z +: 8];
            zm   = zmode_r[8*z +: 8];
            dm   = azb_di_mode_t'(zm[ZM_DI_LO +: 2]);
            hit  = |(zs[3:0] & light_s) | |(zs[7:4] & pres_s);
            qual = (!zm[ZM_PH] && !zm[ZM_RES])
                 || (zm[ZM_PH] && ph_start_i)
                 || (zm[ZM_RES] && res_start_i);
            unique case (dm)
                AZB_DI_LIGHT:   hit = hit || di_s;
                AZB_DI_CURRENT: hit = hit && di_s;
                default:        hit = hit;
            endcase
            pickup[z] = zm[ZM_EN] && qual && hit;
        end
    end

    // Decision made at each cycle start on the held blocking level
    assign trip_new = pickup & ~pick_prev_r & {ZONES{tick_r & ~blk_r}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_r      <= '0;
            blkd_r      <= '0;
            pick_prev_r <= '0;
        end else if (tick_r) begin
            pick_prev_r <= pickup;
            for (int z = 0; z < ZONES; z++) begin
                if (!pickup[z]) begin
                    trip_r[z] <= 1'b0;
                    blkd_r[z] <= 1'b0;
                end else if (!pick_prev_r[z]) begin
                    trip_r[z] <= !blk_r;
                    blkd_r[z] <= blk_r;
                end
            end
        end
    end

    // Live status word, refreshed every clock
    always_ff @(posedge clk_i) begin
        if (rst_i) stat_r <= '0;
        else begin
            stat_r[ST_PH_BLK]               <= ph_start_i && blk_r;
            stat_r[ST_PH_START]             <= ph_start_i;
            stat_r[ST_RES_BLK]              <= res_start_i && blk_r;
            stat_r[ST_RES_START]            <= res_start_i;
            stat_r[ST_LIGHT +: CHANS]       <= light_s;
            stat_r[ST_PRES +: CHANS]        <= pres_s;
            stat_r[ST_DI]                   <= di_s;
            stat_r[ST_SFAULT +: CHANS]      <= pins_s[12:9];
            stat_r[ST_IOFAULT]              <= pins_s[13];
        end
    end

    // Flags 0..7 are zone trip/blocked pairs, then the status word
    always_comb begin
        for (int z = 0; z < ZONES; z++) begin
            flags[2*z]   = trip_r[z];
            flags[2*z+1] = blkd_r[z];
        end
        flags[NFLAG-1:COND_W] = stat_r;
    end

    // One change is reported per clock, lowest index first, so
    // simultaneous changes serialise without a queue
    assign diff   = flags ^ rep_r;
    assign ev_idx = first_set(diff);
    assign wr_acc = wb_cyc_i && wb_stb_i && !ack_r;
    assign cnt_clr = wr_acc && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == REG_CTRL) && wb_dat_i[CTRL_CNT_CLR];

    always_ff @(posedge clk_i) begin
        if (rst_i) ts_r <= '0;
        else if (tick_r) ts_r <= time_ms_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rep_r      <= '0;
            ev_valid_r <= 1'b0;
            ev_id_r    <= '0;
            ev_on_r    <= 1'b0;
            ev_time_r  <= '0;
        end else begin
            ev_valid_r <= 1'b0;
            if (|diff) begin
                rep_r[ev_idx] <= flags[ev_idx];
                ev_id_r       <= ev_idx;
                ev_on_r       <= flags[ev_idx];
                ev_time_r     <= ts_r;
                ev_valid_r    <= flags[ev_idx] ? mask_on_r[ev_idx]
                                               : mask_of_r[ev_idx];
            end
        end
    end

    // An event in the clear cycle still counts
    always_ff @(posedge clk_i) begin
        if (rst_i)        evcnt_r <= '0;
        else if (cnt_clr) evcnt_r <= {31'h0, |diff};
        else if (|diff)   evcnt_r <= evcnt_r + 32'h1;
    end

    // Operation records: ring of twelve, overwrites the oldest
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r  <= '0;
            rec_vld_r <= '0;
        end else if (|trip_new) begin
            wr_ptr_r            <= ring_add(wr_ptr_r, 4'h1);
            rec_vld_r[wr_ptr_r] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (|trip_new) begin
            rec_time_r[wr_ptr_r] <= time_ms_i;
            rec_id_r[wr_ptr_r]   <= EVID_W'(2) * first_set(
                                    NFLAG'(trip_new));
            rec_cur_r[wr_ptr_r]  <= {cur_res_i, cur_c_i, cur_b_i, cur_a_i};
            rec_sens_r[wr_ptr_r] <= {pres_s, light_s};
            rec_sg_r[wr_ptr_r]   <= sg_i;
        end
    end

    // Selected record: 0 is the newest
    assign rd_idx = ring_add(wr_ptr_r, 4'(RECS - 1) - rsel_r);

    // Writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zsens_r   <= ZSENS_RST;
            zmode_r   <= ZMODE_RST;
            mask_on_r <= MASK_RST;
            mask_of_r <= MASK_RST;
            rsel_r    <= '0;
        end else if (wr_acc && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    unique case (wb_adr_i)
                        REG_ZSENS:   zsens_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
                        REG_ZMODE:   zmode_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
                        REG_MASK_ON: begin
                            for (int k = 0; k < 8; k++)
                                if (8*b + k < NFLAG)
                                    mask_on_r[8*b+k] <= wb_dat_i[8*b+k];
                        end
                        REG_MASK_OF: begin
                            for (int k = 0; k < 8; k++)
                                if (8*b + k < NFLAG)
                                    mask_of_r[8*b+k] <= wb_dat_i[8*b+k];
                        end
                        REG_RSEL: begin
                            if (b == 0 && wb_dat_i[3:0] < 4'(RECS))
                                rsel_r <= wb_dat_i[3:0];
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // Bus answer one clock after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= wr_acc;
            dat_r <= '0;
            if (wr_acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    REG_ZSENS:   dat_r <= zsens_r;
                    REG_ZMODE:   dat_r <= zmode_r;
                    REG_COND:    dat_r <= {24'h0, flags[COND_W-1:0]};
                    REG_STAT:    dat_r <= {14'h0, stat_r};
                    REG_MASK_ON: dat_r <= 32'(mask_on_r);
                    REG_MASK_OF: dat_r <= 32'(mask_of_r);
                    REG_EVCNT:   dat_r <= evcnt_r;
                    REG_RSEL:    dat_r <= {28'h0, rsel_r};
                    REG_RTIME:   dat_r <= rec_vld_r[rd_idx]
                                          ? rec_time_r[rd_idx] : 32'h0;
                    REG_RINFO:   dat_r <= {rec_vld_r[rd_idx], 12'h0,
                                           rec_sg_r[rd_idx],
                                           rec_sens_r[rd_idx],
                                           3'h0, rec_id_r[rd_idx]};
                    REG_RCURAB:  dat_r <= rec_cur_r[rd_idx][31:0];
                    REG_RCURCR:  dat_r <= rec_cur_r[rd_idx][63:32];
                    default:     dat_r <= 32'h0;
                endcase
            end
        end
    end

    assign wb_dat_o   = dat_r;
    assign wb_ack_o   = ack_r;
    assign trip_o     = trip_r;
    assign blocked_o  = blkd_r;
    assign status_o   = stat_r;
    assign ev_valid_o = ev_valid_r;
    assign ev_id_o    = ev_id_r;
    assign ev_on_o    = ev_on_r;
    assign ev_time_o  = ev_time_r;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_block_sample: assert property (
        !tick_r |=> $stable(blk_r))
        else $error("blocking level moved outside cycle start");
    chk_trip_clear: assert property (
        tick_r && pickup[0] && !pick_prev_r[0] && !blk_r
        |=> trip_r[0] && !blkd_r[0])
        else $error("unblocked pick-up did not trip");
    chk_block_wins: assert property (
        tick_r && pickup[1] && !pick_prev_r[1] && blk_r
        |=> blkd_r[1] && !trip_r[1])
        else $error("blocked pick-up produced a trip");
    chk_trip_excl: assert property (
        (trip_r & blkd_r) == '0)
        else $error("zone both tripped and blocked");
    chk_event_seen: assert property (
        $rose(trip_r[0]) |-> ##[0:30] (ev_id_r == '0 && ev_on_r))
        else $error("trip ON event missing");
    chk_mask_gate: assert property (
        ev_valid_r |-> (ev_on_r ? mask_on_r[ev_id_r]
                                : mask_of_r[ev_id_r]))
        else $error("masked event reached buffer");
    chk_cnt_step: assert property (
        !cnt_clr && |diff |=> evcnt_r == $past(evcnt_r) + 32'h1)
        else $error("event counter missed an event");
    chk_cnt_clear: assert property (
        cnt_clr && !(|diff) |=> evcnt_r == 32'h0)
        else $error("counter not cleared");
    chk_ring_wrap: assert property (
        wr_ptr_r == 4'(RECS - 1) && |trip_new |=> wr_ptr_r == 4'h0)
        else $error("record ring did not wrap at twelve");
    chk_ack_pulse: assert property (
        ack_r |=> !ack_r)
        else $error("ack held longer than one cycle");

    cov_trip:    cover property (tick_r && trip_new[0]);
    cov_blocked: cover property ($rose(blkd_r[2]));
    cov_event:   cover property (ev_valid_r && !ev_on_r);
    cov_wrap:    cover property (wr_ptr_r == 4'(RECS - 1) && |trip_new);
endmodule // azb_arc_event_block
`default_nettype wire

// *** bench/azb_partner.sv ***
// Far-side model: blocking matrix source and main event buffer
`timescale 1ns/1ps
`default_nettype none
module azb_partner
    import azb_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       blk_req_i,
    output logic                            block_o,
    input  wire logic                       ev_valid_i,
    input  wire logic [azb_pkg::EVID_W-1:0] ev_id_i,
    input  wire logic                       ev_on_i,
    input  wire logic [31:0]                ev_time_i,
    output logic      [31:0]                on_seen_o,
    output logic      [31:0]                off_seen_o,
    output logic      [31:0]                last_time_o
);
    // Matrix drives the blocking level one clock after the bench raises its request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_o <= 1'b0;
        end else begin
            block_o <= blk_req_i;
        end
    end
    // Buffer only remembers which events arrived and the latest stamp
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_seen_o <= 32'h0;
            off_seen_o <= 32'h0;
            last_time_o <= 32'h0;
        end else if (ev_valid_i) begin
            if (ev_on_i) begin
                on_seen_o[ev_id_i] <= 1'b1;
            end else begin
                off_seen_o[ev_id_i] <= 1'b1;
            end
            last_time_o <= ev_time_i;
        end
    end
endmodule // azb_partner
`default_nettype wire

// *** bench/azb_arc_event_block_tb.sv ***
// Self-checking bench for the arc zone blocking and event logic
`timescale 1ns/1ps
`default_nettype none
module azb_arc_event_block_tb;
    import azb_pkg::*;
    localparam logic [31:0] TS = 32'h0000_1234;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, blk_req, block, di;
    logic        wb_ack, ev_valid, ev_on;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel, light, trip, blocked;
    logic [4:0]  ev_id;
    logic [17:0] status;
    logic [31:0] wb_dat, wb_rdat, rd, ev_time, on_seen, off_seen, last_time;
    int          mismatches, checked;

    azb_arc_event_block #(.CYC_CLKS(4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .block_i(block), .ph_start_i(1'b0), .res_start_i(1'b0),
        .light_i(light), .pres_i(4'h0), .di_i(di), .sens_fault_i(4'h0),
        .io_fault_i(1'b0), .time_ms_i(TS), .sg_i(3'h2),
        .cur_a_i(16'h0A11), .cur_b_i(16'h0B22), .cur_c_i(16'h0C33),
        .cur_res_i(16'h0D44), .trip_o(trip), .blocked_o(blocked),
        .status_o(status), .ev_valid_o(ev_valid), .ev_id_o(ev_id),
        .ev_on_o(ev_on), .ev_time_o(ev_time)
    );

    azb_partner part_u (
        .clk_i(clk_i), .rst_i(rst_i), .blk_req_i(blk_req), .block_o(block),
        .ev_valid_i(ev_valid), .ev_id_i(ev_id), .ev_on_i(ev_on),
        .ev_time_i(ev_time), .on_seen_o(on_seen), .off_seen_o(off_seen),
        .last_time_o(last_time)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Holds the request until ack is sampled high, then idles one cycle
    task automatic bus_wait(output logic [31:0] d);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        d = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wb_rd(input logic [7:0] a, output logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_adr <= a;
        bus_wait(d);
    endtask

    task automatic wb_wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] dummy;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= 1'b1;
        wb_adr <= a;
        wb_dat <= v;
        bus_wait(dummy);
    endtask

    // Pick-up passes a synchroniser and a tick, so poll under a bound
    task automatic wait_z(input int z, input bit blk);
        for (int n = 0; n < 60; n++) begin
            @(posedge clk_i);
            if ((blk ? blocked[z] : trip[z]) === 1'b1) break;
        end
    endtask

    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, blk_req, di} = 5'h0;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat = 32'h0;
        light = 4'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(trip), 32'h0);
        wb_rd(REG_MASK_ON, rd);
        chk(rd, 32'(MASK_RST));
        wb_rd(REG_STAT, rd);
        chk(rd, 32'h0);
        wb_wr(REG_ZSENS, 32'h0000_0201);
        wb_wr(REG_ZMODE, 32'h0000_0101);
        light <= 4'h1;
        wait_z(0, 0);
        chk(32'(trip), 32'h1);
        repeat (8) @(posedge clk_i);
        chk(32'(on_seen[0]), 32'h1);
        wb_rd(REG_COND, rd);
        chk(rd, 32'h1);
        wb_rd(REG_STAT, rd);
        chk(rd, 32'h10);
        wb_wr(REG_RSEL, 32'h0);
        wb_rd(REG_RINFO, rd);
        chk(rd, 32'h8002_0100);
        wb_rd(REG_RTIME, rd);
        chk(rd, TS);
        wb_rd(REG_RCURAB, rd);
        chk(rd, 32'h0B22_0A11);
        wb_rd(REG_RCURCR, rd);
        chk(rd, 32'h0D44_0C33);
        wb_wr(REG_RSEL, 32'h1);
        wb_rd(REG_RTIME, rd);
        chk(rd, 32'h0);
        blk_req <= 1'b1;
        repeat (12) @(posedge clk_i);
        light <= 4'h3;
        wait_z(1, 1);
        chk(32'(blocked), 32'h2);
        chk(32'(trip), 32'h1);
        repeat (8) @(posedge clk_i);
        wb_rd(REG_COND, rd);
        chk(rd, 32'h9);
        wb_wr(REG_MASK_OF, 32'h03EF_FFFF);
        wb_wr(REG_CTRL, 32'h1);
        wb_rd(REG_EVCNT, rd);
        chk(rd, 32'h0);
        di <= 1'b1;
        repeat (12) @(posedge clk_i);
        di <= 1'b0;
        repeat (12) @(posedge clk_i);
        wb_rd(REG_EVCNT, rd);
        chk(rd, 32'h2);
        chk(32'(on_seen[20]), 32'h1);
        chk(32'(off_seen[20]), 32'h0);
        chk(last_time, TS);
        wb_rd(8'h3C, rd);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule // azb_arc_event_block_tb
`default_nettype wire
